// [bsdh_pkg.sv]
package bsdh_pkg;

  // ****************************************
  // Control variants
  // ****************************************
  typedef enum logic [1:0] {
    BSDH_PLAIN_HANDSHAKE,
    BSDH_CHAINED,
    BSDH_NO_CONTROL
  } bsdh_variant_e;

  // ****************************************
  // Datapath defaults
  // ****************************************
  localparam int BSDH_DATA_W = 16;
  localparam int BSDH_LATENCY = 4;
  localparam int BSDH_READY_STAGE = 1;
  localparam logic [15:0] BSDH_RESULT_RST = 16'h0000;
  localparam logic [15:0] BSDH_RESULT_ADD = 16'h0001;

endpackage

// [bsdh_datapath.sv]
`timescale 1ns/1ps

// Worker: inputs read in the first cycle, result ready after LATENCY cycles.
module bsdh_datapath
  import bsdh_pkg::*;
#(
  parameter int DATA_W = BSDH_DATA_W,
  parameter int LATENCY = BSDH_LATENCY
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic launch,
  input wire logic hold,
  input wire logic [DATA_W-1:0] operand,
  output logic [DATA_W-1:0] result,
  output logic last_cycle
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] next_acc;

  always_comb begin
    next_count = count;
    next_acc = acc;
    if (launch) begin
      next_count = 8'(LATENCY - 1);
      next_acc = operand;
    end else if (!hold && count != 8'h00) begin
      next_count = count - 8'h01;
      next_acc = acc + DATA_W'(BSDH_RESULT_ADD);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 8'h00;
      acc <= DATA_W'(BSDH_RESULT_RST);
    end else begin
      count <= next_count;
      acc <= next_acc;
    end
  end

  assign result = acc;
  assign last_cycle = (count == 8'h01);

endmodule // bsdh_datapath

// [bsdh_ctrl.sv]
`timescale 1ns/1ps

module bsdh_ctrl
  import bsdh_pkg::*;
#(
  parameter bsdh_variant_e VARIANT = BSDH_PLAIN_HANDSHAKE,
  parameter bit PIPELINED = 1'b0,
  parameter bit HAS_RETURN = 1'b1,
  parameter int DATA_W = BSDH_DATA_W,
  parameter int LATENCY = BSDH_LATENCY
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic START_REQ,
  input wire logic CONTINUE_IN,
  input wire logic [DATA_W-1:0] OPERAND,
  output logic IDLE_FLAG,
  output logic READY_FLAG,
  output logic DONE_FLAG,
  output logic [DATA_W-1:0] RETURN_VALUE
);

  // ****************************************
  // Variant decode
  // ****************************************
  // Ports of unused variants stay in the header but are tied off inside,
  // so one netlist shape serves all three variants.
  localparam bit NO_CTRL = (VARIANT == BSDH_NO_CONTROL);
  localparam bit CHAINED = (VARIANT == BSDH_CHAINED);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_HOLD
  } bsdh_state_e;

  bsdh_state_e state;
  bsdh_state_e next_state;
  logic idle_q;
  logic next_idle;
  logic ready_q;
  logic next_ready;
  logic done_q;
  logic next_done;
  logic [DATA_W-1:0] ret_q;
  logic [DATA_W-1:0] next_ret;
  logic [7:0] age;
  logic [7:0] next_age;
  logic ready_seen;
  logic next_ready_seen;
  logic start_eff;
  logic cont_eff;
  logic launch;
  logic hold;
  logic last_cycle;
  logic [DATA_W-1:0] dp_result;

  // No-control blocks run freely; plain blocks never see back-pressure
  assign start_eff = NO_CTRL ? 1'b1 : START_REQ;
  assign cont_eff = CHAINED ? CONTINUE_IN : 1'b1;

  // ****************************************
  // Worker
  // ****************************************
  bsdh_datapath #(
    .DATA_W(DATA_W),
    .LATENCY(LATENCY)
  ) u_dp (
    .clk(CLK),
    .rst(SYS_RST),
    .launch(launch),
    .hold(hold),
    .operand(OPERAND),
    .result(dp_result),
    .last_cycle(last_cycle)
  );

  // ****************************************
  // Handshake control
  // ****************************************
  // Done is registered so the result and done_flag leave flops together.
  always_comb begin
    next_state = state;
    next_idle = idle_q;
    next_ready = 1'b0;
    next_done = 1'b0;
    next_ret = ret_q;
    next_age = age;
    next_ready_seen = ready_seen;
    launch = 1'b0;
    hold = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (start_eff) begin
          launch = 1'b1;
          next_state = ST_RUN;
          next_idle = 1'b0;
          next_age = 8'h01;
          next_ready_seen = 1'b0;
        end
      end
      ST_RUN: begin
        next_age = (age == 8'hFF) ? age : age + 8'h01;
        // Pipelined: accept next inputs at a fixed early stage
        if (PIPELINED && !ready_seen && age == 8'(BSDH_READY_STAGE)) begin
          next_ready = 1'b1;
          next_ready_seen = 1'b1;
        end
        if (last_cycle) begin
          next_done = 1'b1;
          next_ret = dp_result;
          if (!PIPELINED || !ready_seen) begin
            next_ready = 1'b1;
          end
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // done_flag is on the pins this cycle
        if (!cont_eff) begin
          next_done = 1'b1;
          hold = 1'b1;
        end else if (start_eff) begin
          launch = 1'b1;
          next_state = ST_RUN;
          next_age = 8'h01;
          next_ready_seen = 1'b0;
          next_idle = 1'b0;
        end else begin
          next_state = ST_IDLE;
          next_idle = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_idle = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
      idle_q <= 1'b1;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      ret_q <= DATA_W'(BSDH_RESULT_RST);
      age <= 8'h00;
      ready_seen <= 1'b0;
    end else begin
      state <= next_state;
      idle_q <= next_idle;
      ready_q <= next_ready;
      done_q <= next_done;
      ret_q <= next_ret;
      age <= next_age;
      ready_seen <= next_ready_seen;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // A function without a result keeps the port at zero
  assign IDLE_FLAG = NO_CTRL ? 1'b0 : idle_q;
  assign READY_FLAG = NO_CTRL ? 1'b0 : ready_q;
  assign DONE_FLAG = NO_CTRL ? 1'b0 : done_q;
  assign RETURN_VALUE = HAS_RETURN ? ret_q : '0;

  // ****************************************
  // Checks
  // ****************************************
  property p_reset_idle;
    @(posedge CLK) $past(SYS_RST) |-> idle_q && !ready_q && !done_q;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bad reset state");

  property p_stay_idle;
    @(posedge CLK) disable iff (SYS_RST)
      (state == ST_IDLE && !start_eff) |=> (state == ST_IDLE && !ready_q && !done_q);
  endproperty
  a_stay_idle: assert property (p_stay_idle) else $error("started without start");

  property p_idle_drop;
    @(posedge CLK) disable iff (SYS_RST)
      (state == ST_IDLE && start_eff) |=> !idle_q;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("idle not dropped");

  property p_ready_with_done;
    @(posedge CLK) disable iff (SYS_RST)
      (!PIPELINED && $rose(done_q)) |-> ready_q;
  endproperty
  a_ready_with_done: assert property (p_ready_with_done) else $error("ready not with done");

  property p_idle_after_done;
    @(posedge CLK) disable iff (SYS_RST)
      (done_q && cont_eff && !start_eff) |=> idle_q && !done_q;
  endproperty
  a_idle_after_done: assert property (p_idle_after_done) else $error("idle late");

  property p_continue_busy;
    @(posedge CLK) disable iff (SYS_RST)
      (done_q && cont_eff && start_eff) |=> !idle_q ##1 !idle_q;
  endproperty
  a_continue_busy: assert property (p_continue_busy) else $error("idle while continuing");

  property p_stall_hold;
    @(posedge CLK) disable iff (SYS_RST)
      (done_q && !cont_eff) |=> done_q && $stable(ret_q);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall lost done");

  property p_done_latency;
    @(posedge CLK) disable iff (SYS_RST)
      (state == ST_IDLE && start_eff && cont_eff) |-> ##LATENCY done_q;
  endproperty
  a_done_latency: assert property (p_done_latency) else $error("done late");

  property p_ready_after_start;
    @(posedge CLK) disable iff (SYS_RST)
      $rose(ready_q) |-> !idle_q;
  endproperty
  a_ready_after_start: assert property (p_ready_after_start) else $error("ready while idle");

  c_start: cover property (@(posedge CLK) state == ST_IDLE && start_eff);
  c_back_to_back: cover property (@(posedge CLK) done_q && start_eff && cont_eff);
  c_stall: cover property (@(posedge CLK) done_q && !cont_eff ##1 done_q);
  c_stop: cover property (@(posedge CLK) done_q ##1 idle_q);

endmodule // bsdh_ctrl

// [bsdh_partner.sv]
`timescale 1ns/1ps

// Upstream controller and downstream consumer around the block
module bsdh_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic want,
  input wire logic stall,
  input wire logic ready,
  output logic start,
  output logic cont
);
  // A raised request may only change once ready was seen, so no start is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      start <= 1'b0;
    end else if (!start || ready) begin
      start <= want;
    end
  end

  // Consumer readiness; a stall withholds it like a busy downstream block
  always_ff @(posedge clk) begin
    cont <= rst ? 1'b1 : !stall;
  end
endmodule // bsdh_partner

// [tb_block_level_start_done_handshake.sv]
`timescale 1ns/1ps

module tb_block_level_start_done_handshake;
  import bsdh_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic want = 1'b0;
  logic stall = 1'b0;
  logic [BSDH_DATA_W-1:0] operand = '0;
  logic start_req, continue_in, idle_flag, ready_flag, done_flag;
  logic start2, idle2, ready2, done2, idle3, ready3, done3;
  logic [BSDH_DATA_W-1:0] return_value, exp_r, ret2, exp2;
  logic busy = 1'b0, busy2 = 1'b0, armed = 1'b0, mdone, mdone2;
  int age = 0, age2 = 0, n_fail = 0, compares = 0, n_done = 0;
  integer seed = 32'hD0E42BE3;

  always #5 clk = ~clk;

  bsdh_ctrl #(.VARIANT(BSDH_CHAINED)) dut (
    .CLK(clk), .SYS_RST(sys_rst), .START_REQ(start_req), .CONTINUE_IN(continue_in),
    .OPERAND(operand), .IDLE_FLAG(idle_flag), .READY_FLAG(ready_flag),
    .DONE_FLAG(done_flag), .RETURN_VALUE(return_value)
  );

  bsdh_partner partner (
    .clk(clk), .rst(sys_rst), .want(want), .stall(stall), .ready(ready_flag),
    .start(start_req), .cont(continue_in)
  );

  // Plain and pipelined: back-pressure must be ignored, so continue is held low
  bsdh_ctrl #(.VARIANT(BSDH_PLAIN_HANDSHAKE), .PIPELINED(1'b1)) dut_pipe (
    .CLK(clk), .SYS_RST(sys_rst), .START_REQ(start2), .CONTINUE_IN(1'b0),
    .OPERAND(operand), .IDLE_FLAG(idle2), .READY_FLAG(ready2),
    .DONE_FLAG(done2), .RETURN_VALUE(ret2)
  );

  bsdh_partner partner_pipe (
    .clk(clk), .rst(sys_rst), .want(want), .stall(stall), .ready(ready2),
    .start(start2), .cont()
  );

  // No control: runs freely while every handshake input stays low
  bsdh_ctrl #(.VARIANT(BSDH_NO_CONTROL)) dut_free (
    .CLK(clk), .SYS_RST(sys_rst), .START_REQ(1'b0), .CONTINUE_IN(1'b0),
    .OPERAND(operand), .IDLE_FLAG(idle3), .READY_FLAG(ready3),
    .DONE_FLAG(done3), .RETURN_VALUE()
  );

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [BSDH_DATA_W-1:0] got, input logic [BSDH_DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: result got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Reference model, fed from pre-edge values
  // ****************************************
  // Done shows LATENCY-1 cycles after the launch edge; the captured result
  // trails the worker's last step by one increment
  always @(posedge clk) begin
    armed = 1'b1;
    mdone = busy && age >= BSDH_LATENCY - 1;
    if (sys_rst) begin
      busy = 1'b0;
      age = 0;
    end else if (start_req && (!busy || (mdone && continue_in))) begin
      busy = 1'b1;
      age = 0;
      exp_r = operand + BSDH_DATA_W'(BSDH_LATENCY - 2);
    end else if (mdone && continue_in) begin
      busy = 1'b0;
    end else begin
      age++;
    end
  end

  // Plain pipelined model: no back-pressure, ready early in the run
  always @(posedge clk) begin
    mdone2 = busy2 && age2 == BSDH_LATENCY - 1;
    if (sys_rst) begin
      busy2 = 1'b0;
      age2 = 0;
    end else if (start2 && (!busy2 || mdone2)) begin
      busy2 = 1'b1;
      age2 = 0;
      exp2 = operand + BSDH_DATA_W'(BSDH_LATENCY - 2);
    end else if (mdone2) begin
      busy2 = 1'b0;
    end else begin
      age2++;
    end
  end

  always @(negedge clk) begin
    if (armed) begin
      mdone = busy && age >= BSDH_LATENCY - 1;
      n_done += (ready_flag === 1'b1);
      chk_bit(done_flag, mdone);
      chk_bit(ready_flag, busy && age == BSDH_LATENCY - 1);
      if (mdone) chk_word(return_value, exp_r);
      if (!busy) chk_bit(idle_flag, 1'b1);
      else chk_bit(idle_flag, 1'b0);
      mdone2 = busy2 && age2 == BSDH_LATENCY - 1;
      chk_bit(done2, mdone2);
      chk_bit(ready2, busy2 && age2 == BSDH_READY_STAGE);
      if (mdone2) chk_word(ret2, exp2);
      chk_bit(idle2, !busy2);
      chk_bit(idle3 | ready3 | done3, 1'b0);
    end
  end

  // ****************************************
  // Phases: idle, back to back, mixed, heavy stall, reset mid-run
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int ph = 0; ph < 5; ph++) begin
      for (int i = 0; i < 600; i++) begin
        @(posedge clk);
        operand <= BSDH_DATA_W'($random(seed));
        want <= ph == 0 ? 1'b0 : ph == 2 ? (($random(seed) & 3) != 0) : 1'b1;
        stall <= ph == 1 ? 1'b0 : ph == 3 ? (($random(seed) & 7) != 0) : (($random(seed) & 7) == 0);
        // Reset in mid-transaction must drop everything back to idle
        sys_rst <= ph == 4 && i > 100 && i < 103;
      end
    end
    chk_bit(n_done > 100, 1'b1);
    print_verdict();
  end
endmodule // tb_block_level_start_done_handshake
